/* File: hdl/bus_front_device.sv */
// Contract
// RQ1: Capture address on latch strobe, ALE or AS.
// RQ2: Drive data only when reading and selected.
// RQ3: Pass port addresses to decode logic.
// RQ4: Multiplexed host: AD low, A8-15 upper.
// RQ5: Non-multiplexed host: A0-7 low, A8-15 upper.
// RQ6: Page mode: A0-7 low, AD8-15 upper.
// RQ7: Burst mode: A4-11/D0-7 low, A12-19/D8-15 upper.
// RQ8: Write input is strobe or read/write level.
// RQ9: Read input is strobe, E, DS or fetch.
// RQ10: Write and read inputs feed the logic.
// RQ11: Third input is fetch enable or general.
// RQ12: Reset clears ports, macrocells, some configuration.
// RQ13: Reset held low during power-up.
// RQ14: Latch transparent while strobe active, then holds.
module bus_front_device (
   input wire logic clk_i,
   input wire logic rstn_i,
   bus_front_if.device bus,
   input wire bus_front_pkg::bus_style_t style_i,
   input wire logic latch_sel_i,
   input wire logic wr_mode_i,
   input wire logic [1:0] rd_mode_i,
   input wire logic fetch_present_i,
   input wire logic block_selected_i,
   input wire logic [15:0] rd_data_i,
   output logic [15:0] addr_o,
   output logic [7:0] lower_raw_o,
   output logic [7:0] upper_raw_o,
   output logic [15:0] wr_data_o,
   output logic read_active_o,
   output logic write_active_o,
   output logic wr_term_o,
   output logic rd_term_o,
   output logic fetch_term_o,
   output logic general_in_o,
   output logic port_reset_o
);
   import bus_front_pkg::*;

   // Which ports carry data for a host style; non-multiplexed data lives elsewhere
   function automatic logic carries_data(input bus_style_t style, input logic upper);
      logic hit;
      hit = upper ? (style == STYLE_PAGE) : (style == STYLE_MUX);
      return hit | (style == STYLE_BURST);
   endfunction

   // ==========================================
   // Pin synchronisers
   // ==========================================
   // Three stages; a change counts once the last two agree
   logic [SYNC_STAGES-1:0] s_strobe_q, s_wr_q, s_rd_q, s_fetch_q, s_rst_q;
   logic [7:0] lo_s1_q, lo_s2_q, lo_s3_q, up_s1_q, up_s2_q, up_s3_q;
   logic strobe_q, wr_q, rd_q, fetch_q, ext_rst_q;
   logic [7:0] lo_q, up_q;

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         s_strobe_q <= '0;
         s_wr_q <= '1;
         s_rd_q <= '1;
         s_fetch_q <= '1;
         s_rst_q <= '0;
         lo_s1_q <= ADDR_RST;
         lo_s2_q <= ADDR_RST;
         lo_s3_q <= ADDR_RST;
         up_s1_q <= ADDR_RST;
         up_s2_q <= ADDR_RST;
         up_s3_q <= ADDR_RST;
      end
      else
      begin
         s_strobe_q <= {s_strobe_q[1:0], bus.latch_strobe};
         s_wr_q <= {s_wr_q[1:0], bus.write_control_input};
         s_rd_q <= {s_rd_q[1:0], bus.read_control_input};
         s_fetch_q <= {s_fetch_q[1:0], bus.program_fetch_input};
         s_rst_q <= {s_rst_q[1:0], bus.reset_n};
         lo_s1_q <= bus.lower_level;
         lo_s2_q <= lo_s1_q;
         lo_s3_q <= lo_s2_q;
         up_s1_q <= bus.upper_level;
         up_s2_q <= up_s1_q;
         up_s3_q <= up_s2_q;
      end
   end

   // Filtered levels change only when stages two and three agree
   wire strobe_ok = s_strobe_q[1] == s_strobe_q[2];
   wire wr_ok = s_wr_q[1] == s_wr_q[2];
   wire rd_ok = s_rd_q[1] == s_rd_q[2];
   wire fetch_ok = s_fetch_q[1] == s_fetch_q[2];
   wire rst_ok = s_rst_q[1] == s_rst_q[2];
   wire [7:0] lo_ok = ~(lo_s2_q ^ lo_s3_q);
   wire [7:0] up_ok = ~(up_s2_q ^ up_s3_q);

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         strobe_q <= 1'b0;
         wr_q <= 1'b1;
         rd_q <= 1'b1;
         fetch_q <= 1'b1;
         ext_rst_q <= 1'b0;
         lo_q <= ADDR_RST;
         up_q <= ADDR_RST;
      end
      else
      begin
         if (strobe_ok) strobe_q <= s_strobe_q[2];
         if (wr_ok) wr_q <= s_wr_q[2];
         if (rd_ok) rd_q <= s_rd_q[2];
         if (fetch_ok) fetch_q <= s_fetch_q[2];
         if (rst_ok) ext_rst_q <= s_rst_q[2];
         lo_q <= (lo_ok & lo_s3_q) | (~lo_ok & lo_q);
         up_q <= (up_ok & up_s3_q) | (~up_ok & up_q);
      end
   end

   // ==========================================
   // Control decode
   // ==========================================
   // Both latch sources are high-active strobes on one pin
   wire latch_open = (latch_sel_i == LATCH_AS) ? strobe_q : strobe_q;
   wire rd_now = (rd_mode_i == RD_MODE_ECLK) ? rd_q : ~rd_q; // RQ9
   wire wr_now = (wr_mode_i == WR_MODE_RNW) ? (~wr_q & ~latch_open) : ~wr_q; // RQ8
   wire rnw_read = (wr_mode_i == WR_MODE_RNW) ? wr_q : 1'b1;
   wire rd_eff = rd_now & rnw_read;
   wire in_reset = ~ext_rst_q; // RQ12

   // Data lanes per host style: which ports carry data
   wire lo_data = carries_data(style_i, 1'b0);
   wire up_data = carries_data(style_i, 1'b1);
   wire drive = rd_eff & block_selected_i & ~in_reset; // RQ2
   wire [15:0] wr_lanes = {up_data ? up_q : DATA_RST, lo_data ? lo_q : DATA_RST};

   // ==========================================
   // Address latch
   // ==========================================
   // Transparent while the filtered strobe is high; holds from its first low cycle
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         addr_o <= {ADDR_RST, ADDR_RST};
      else if (in_reset)
         addr_o <= {ADDR_RST, ADDR_RST}; // RQ12
      else if (latch_open)
         addr_o <= {up_q, lo_q}; // RQ1 RQ14
   end

   // ==========================================
   // Write capture and bus status
   // ==========================================
   // Taken on every cycle of the write, so the last settled lanes win
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         wr_data_o <= {DATA_RST, DATA_RST};
         read_active_o <= 1'b0;
         write_active_o <= 1'b0;
      end
      else
      begin
         if (wr_now)
            wr_data_o <= wr_lanes;
         read_active_o <= rd_eff; // RQ9
         write_active_o <= wr_now; // RQ8
      end
   end

   // ==========================================
   // Terms for the programmable logic
   // ==========================================
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         lower_raw_o <= ADDR_RST;
         upper_raw_o <= ADDR_RST;
         wr_term_o <= 1'b1;
         rd_term_o <= 1'b1;
         fetch_term_o <= 1'b1;
         general_in_o <= 1'b1;
         port_reset_o <= 1'b1;
      end
      else
      begin
         lower_raw_o <= lo_q; // RQ3
         upper_raw_o <= up_q; // RQ3
         wr_term_o <= wr_q; // RQ10
         rd_term_o <= rd_q; // RQ10
         fetch_term_o <= fetch_present_i ? fetch_q : 1'b1; // RQ11
         general_in_o <= fetch_present_i ? 1'b1 : fetch_q; // RQ11
         port_reset_o <= in_reset; // RQ12
      end
   end

   // ==========================================
   // Data pin drivers
   // ==========================================
   // Enables trail the read pin by the filter delay; a host must keep the
   // data lanes released for the whole read strobe and the filter delay after it to avoid contention
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         bus.lower_addr_data_port_dev <= DATA_RST;
         bus.lower_addr_data_port_dev_oe <= 8'h00;
         bus.upper_addr_data_port_dev <= DATA_RST;
         bus.upper_addr_data_port_dev_oe <= 8'h00;
      end
      else
      begin
         bus.lower_addr_data_port_dev <= rd_data_i[7:0];
         bus.upper_addr_data_port_dev <= rd_data_i[15:8];
         bus.lower_addr_data_port_dev_oe <= {8{drive & lo_data}}; // RQ2
         bus.upper_addr_data_port_dev_oe <= {8{drive & up_data}}; // RQ2
      end
   end
endmodule

/* File: hdl/bus_front_pkg.sv */
package bus_front_pkg;
   // Host bus styles
   typedef enum logic [3:0] {
      STYLE_MUX   = 4'h1,
      STYLE_NOMUX = 4'h2,
      STYLE_PAGE  = 4'h4,
      STYLE_BURST = 4'h8
   } bus_style_t;

   // Write control meaning
   localparam logic WR_MODE_STROBE = 1'h0;
   localparam logic WR_MODE_RNW = 1'h1;

   // Read control meaning
   localparam logic [1:0] RD_MODE_STROBE = 2'h0;
   localparam logic [1:0] RD_MODE_ECLK = 2'h1;
   localparam logic [1:0] RD_MODE_DSTROBE = 2'h2;
   localparam logic [1:0] RD_MODE_FETCH = 2'h3;

   // Latch strobe polarity: ale high-active, addr_valid_strobe high-active
   localparam logic LATCH_ALE = 1'h0;
   localparam logic LATCH_AS = 1'h1;

   localparam int PORT_W = 8;
   localparam int SYNC_STAGES = 3;
   // Host bus phase lasts this many clocks plus one
   localparam logic [2:0] PHASE_CYCLES = 3'h6;
   localparam logic [7:0] ADDR_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
endpackage

/* File: hdl/bus_front_if.sv */
interface bus_front_if;
   import bus_front_pkg::*;
   logic [7:0] lower_addr_data_port_host;
   logic [7:0] lower_addr_data_port_host_oe;
   logic [7:0] lower_addr_data_port_dev;
   logic [7:0] lower_addr_data_port_dev_oe;
   logic [7:0] upper_addr_data_port_host;
   logic [7:0] upper_addr_data_port_host_oe;
   logic [7:0] upper_addr_data_port_dev;
   logic [7:0] upper_addr_data_port_dev_oe;
   logic [7:0] lower_level;
   logic [7:0] upper_level;
   logic latch_strobe;
   logic write_control_input;
   logic read_control_input;
   logic program_fetch_input;
   logic reset_n;

   // Wire levels resolved from both drivers; undriven bits read high (pull-up)
   assign lower_level = (lower_addr_data_port_host & lower_addr_data_port_host_oe) |
      (lower_addr_data_port_dev & lower_addr_data_port_dev_oe) |
      ~(lower_addr_data_port_host_oe | lower_addr_data_port_dev_oe);
   assign upper_level = (upper_addr_data_port_host & upper_addr_data_port_host_oe) |
      (upper_addr_data_port_dev & upper_addr_data_port_dev_oe) |
      ~(upper_addr_data_port_host_oe | upper_addr_data_port_dev_oe);

   modport device (
      input lower_level, upper_level, latch_strobe, write_control_input,
      input read_control_input, program_fetch_input, reset_n,
      output lower_addr_data_port_dev, lower_addr_data_port_dev_oe,
      output upper_addr_data_port_dev, upper_addr_data_port_dev_oe
   );
   modport host (
      input lower_level, upper_level,
      output lower_addr_data_port_host, lower_addr_data_port_host_oe,
      output upper_addr_data_port_host, upper_addr_data_port_host_oe,
      output latch_strobe, write_control_input, read_control_input,
      output program_fetch_input, reset_n
   );
endinterface

/* File: hdl/bus_front_host.sv */
module bus_front_host (
   input wire logic clk_i,
   input wire logic rstn_i,
   bus_front_if.host bus,
   input wire bus_front_pkg::bus_style_t style_i,
   input wire logic start_i,
   input wire logic write_i,
   input wire logic [19:0] addr_i,
   input wire logic [15:0] wdata_i,
   output logic [15:0] rdata_o,
   output logic busy_o,
   output logic done_o
);
   import bus_front_pkg::*;

   typedef enum logic [3:0] {
      H_IDLE = 4'h1,
      H_ADDR = 4'h2,
      H_DATA = 4'h4,
      H_END = 4'h8
   } host_state_t;

   host_state_t state_q;
   logic [2:0] cnt_q;
   logic wr_q;
   logic [15:0] wdata_q;
   logic [19:0] addr_q;

   // ==========================================
   // Lane mapping per host style
   // ==========================================
   wire [7:0] lo_addr = (style_i == STYLE_BURST) ? addr_q[11:4] : addr_q[7:0]; // RQ4 RQ5 RQ6 RQ7
   wire [7:0] up_addr = (style_i == STYLE_BURST) ? addr_q[19:12] : addr_q[15:8]; // RQ4 RQ5 RQ6 RQ7
   wire lo_data = (style_i == STYLE_MUX) | (style_i == STYLE_BURST);
   wire up_data = (style_i == STYLE_PAGE) | (style_i == STYLE_BURST);
   wire phase_end = cnt_q == PHASE_CYCLES;

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state_q <= H_IDLE;
         cnt_q <= 3'h0;
         wr_q <= 1'b0;
         wdata_q <= 16'h0000;
         addr_q <= 20'h00000;
         rdata_o <= 16'h0000;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         bus.reset_n <= 1'b0; // RQ13
         bus.latch_strobe <= 1'b0;
         bus.write_control_input <= 1'b1;
         bus.read_control_input <= 1'b1;
         bus.program_fetch_input <= 1'b1;
         bus.lower_addr_data_port_host <= 8'h00;
         bus.lower_addr_data_port_host_oe <= 8'h00;
         bus.upper_addr_data_port_host <= 8'h00;
         bus.upper_addr_data_port_host_oe <= 8'h00;
      end
      else
      begin
         bus.reset_n <= 1'b1;
         done_o <= 1'b0;
         cnt_q <= phase_end ? 3'h0 : cnt_q + 3'h1;
         unique case (state_q)
            H_IDLE:
            begin
               cnt_q <= 3'h0;
               if (start_i)
               begin
                  state_q <= H_ADDR;
                  busy_o <= 1'b1;
                  wr_q <= write_i;
                  addr_q <= addr_i;
                  wdata_q <= wdata_i;
               end
            end
            H_ADDR:
            begin
               bus.latch_strobe <= ~phase_end;
               bus.lower_addr_data_port_host <= lo_addr;
               bus.upper_addr_data_port_host <= up_addr;
               bus.lower_addr_data_port_host_oe <= 8'hff;
               bus.upper_addr_data_port_host_oe <= 8'hff;
               if (phase_end)
                  state_q <= H_DATA;
            end
            H_DATA:
            begin
               bus.lower_addr_data_port_host <= lo_data ? wdata_q[7:0] : lo_addr;
               bus.upper_addr_data_port_host <= up_data ? wdata_q[15:8] : up_addr;
               bus.lower_addr_data_port_host_oe <= (lo_data & ~wr_q) ? 8'h00 : 8'hff;
               bus.upper_addr_data_port_host_oe <= (up_data & ~wr_q) ? 8'h00 : 8'hff;
               bus.write_control_input <= ~wr_q; // RQ8
               bus.read_control_input <= wr_q; // RQ9
               if (phase_end)
               begin
                  state_q <= H_END;
                  rdata_o <= {up_data ? bus.upper_level : 8'h00,
                     lo_data ? bus.lower_level : 8'h00};
               end
            end
            H_END:
            begin
               bus.write_control_input <= 1'b1;
               bus.read_control_input <= 1'b1;
               bus.lower_addr_data_port_host_oe <= 8'h00;
               bus.upper_addr_data_port_host_oe <= 8'h00;
               if (phase_end)
               begin
                  state_q <= H_IDLE;
                  busy_o <= 1'b0;
                  done_o <= 1'b1;
               end
            end
            default:
               state_q <= H_IDLE;
         endcase
      end
   end
endmodule

/* File: tb/bus_front_checker.sv */
module bus_front_checker (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [7:0] lower_addr_data_port_host_oe,
   input wire logic [7:0] lower_addr_data_port_dev_oe,
   input wire logic [7:0] upper_addr_data_port_host_oe,
   input wire logic [7:0] upper_addr_data_port_dev_oe,
   input wire logic latch_strobe,
   input wire logic write_control_input,
   input wire logic read_control_input,
   input wire logic reset_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // Helper counters
   // ==========================================
   logic [3:0] idle_q;
   logic [3:0] rel_q;
   wire logic dev_on = (lower_addr_data_port_dev_oe | upper_addr_data_port_dev_oe) != 8'h00;
   wire logic [3:0] idle_d = !read_control_input ? 4'h0 : (idle_q == 4'hf ? idle_q : idle_q + 4'h1);
   wire logic [3:0] rel_d = (rel_q == 4'hf) ? rel_q : rel_q + 4'h1;
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         idle_q <= 4'hf;
         rel_q <= 4'h0;
      end
      else
      begin
         idle_q <= idle_d;
         rel_q <= rel_d;
      end
   end
   // ==========================================
   // Properties
   // ==========================================
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_addr_phase;
      latch_strobe[*5];
   endsequence
   a_addr_on_ports: assert property (
      latch_strobe |-> (lower_addr_data_port_host_oe & upper_addr_data_port_host_oe) == 8'hff)
      else $error("address not driven on both ports during latch");
   a_strobe_holds: assert property ($rose(latch_strobe) |-> s_addr_phase)
      else $error("latch strobe too short");
   a_strobe_alone: assert property (
      latch_strobe |-> read_control_input && write_control_input)
      else $error("control strobe active while latching");
   a_drive_on_read: assert property (dev_on |-> idle_q <= 4'h7)
      else $error("device drives without a recent read");
   a_release_after_read: assert property (
      $rose(read_control_input) |-> ##[0:8] !dev_on)
      else $error("device keeps driving after read");
   a_quiet_on_write: assert property (!write_control_input |-> !dev_on)
      else $error("device drives during write");
   a_no_contention: assert property (
      ((lower_addr_data_port_host_oe & lower_addr_data_port_dev_oe) |
      (upper_addr_data_port_host_oe & upper_addr_data_port_dev_oe)) == 8'h00)
      else $error("both ends drive one lane");
   a_reset_released: assert property (rel_q >= 4'h2 |-> reset_n)
      else $error("reset pin low after release");
endmodule

/* File: tb/tb.sv */
module tb;
   import bus_front_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   bus_style_t style_i = STYLE_MUX;
   logic latch_sel_i = 1'b0;
   logic wr_mode_i = WR_MODE_STROBE;
   logic [1:0] rd_mode_i = RD_MODE_STROBE;
   logic fetch_present_i = 1'b0;
   logic block_selected_i = 1'b1;
   logic [15:0] rd_data_i = 16'h0000;
   logic start_i = 1'b0;
   logic write_i = 1'b0;
   logic [19:0] addr_i = 20'h00000;
   logic [15:0] wdata_i = 16'h0000;
   wire logic [15:0] addr_o, wr_data_o, rdata_o;
   wire logic wr_term_o, rd_term_o, fetch_term_o, general_in_o, port_reset_o, done_o;
   wire logic [7:0] lower_raw_o, upper_raw_o;
   wire logic read_active_o, write_active_o;
   int exp_q[$];
   int fail_count = 0;
   int checked = 0;
   integer seed = 32'h12507fe4;
   bus_style_t st[4] = '{STYLE_MUX, STYLE_NOMUX, STYLE_PAGE, STYLE_BURST};
   always #4 clk_i = ~clk_i;
   // ==========================================
   // Two ends joined by the interface
   // ==========================================
   bus_front_if bus_front_if_inst ();
   bus_front_host bus_front_host_inst (.clk_i, .rstn_i, .bus(bus_front_if_inst), .style_i,
      .start_i, .write_i, .addr_i, .wdata_i, .rdata_o, .busy_o(), .done_o);
   bus_front_device bus_front_device_inst (.clk_i, .rstn_i, .bus(bus_front_if_inst), .style_i,
      .latch_sel_i, .wr_mode_i, .rd_mode_i, .fetch_present_i, .block_selected_i, .rd_data_i,
      .addr_o, .lower_raw_o, .upper_raw_o, .wr_data_o, .read_active_o,
      .write_active_o, .wr_term_o, .rd_term_o, .fetch_term_o, .general_in_o, .port_reset_o);
   bus_front_checker bus_front_checker_inst (.clk_i, .rstn_i,
      .lower_addr_data_port_host_oe(bus_front_if_inst.lower_addr_data_port_host_oe),
      .lower_addr_data_port_dev_oe(bus_front_if_inst.lower_addr_data_port_dev_oe),
      .upper_addr_data_port_host_oe(bus_front_if_inst.upper_addr_data_port_host_oe),
      .upper_addr_data_port_dev_oe(bus_front_if_inst.upper_addr_data_port_dev_oe),
      .latch_strobe(bus_front_if_inst.latch_strobe),
      .write_control_input(bus_front_if_inst.write_control_input),
      .read_control_input(bus_front_if_inst.read_control_input),
      .reset_n(bus_front_if_inst.reset_n));
   // ==========================================
   // Checking and transfer tasks
   // ==========================================
   task automatic print_verdict();
      if (fail_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] mask);
      checked++;
      if ((got & mask) !== (exp & mask))
      begin
         fail_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input bus_style_t s);
      logic [15:0] lanes;
      logic [15:0] port_addr;
      logic seen_rd;
      logic seen_wr;
      int n;
      @(negedge clk_i);
      style_i = s;
      write_i = w;
      addr_i = 20'($random(seed));
      wdata_i = 16'($random(seed));
      rd_data_i = 16'($random(seed));
      start_i = 1'b1;
      // Data lanes per host style; non-multiplexed data lives elsewhere
      lanes = s == STYLE_MUX ? 16'h00ff : s == STYLE_PAGE ? 16'hff00 :
         s == STYLE_BURST ? 16'hffff : 16'h0000;
      port_addr = s == STYLE_BURST ? addr_i[19:4] : addr_i[15:0];
      // Model queue: latched address, then the word the data lanes must carry
      exp_q.push_back(int'(port_addr));
      exp_q.push_back(w ? int'(wdata_i & lanes) :
         int'(block_selected_i ? rd_data_i : 16'hffff));
      @(negedge clk_i);
      start_i = 1'b0;
      n = 0;
      seen_rd = 1'b0;
      seen_wr = 1'b0;
      while (done_o !== 1'b1 && n < 200)
      begin
         @(negedge clk_i);
         n++;
         seen_rd = seen_rd | (read_active_o === 1'b1);
         seen_wr = seen_wr | (write_active_o === 1'b1);
         // Mid address phase: filtered port values hold the address
         if (n == 8)
            check({upper_raw_o, lower_raw_o}, port_addr, 16'hffff);
      end
      if (n == 200)
      begin
         fail_count++;
         $display("ERROR %0t: transfer never completed", $time);
         print_verdict();
      end
      else
      begin
         check(addr_o, 16'(exp_q.pop_front()), 16'hffff);
         if (w)
            check(wr_data_o, 16'(exp_q.pop_front()), 16'hffff);
         else
            check(rdata_o, 16'(exp_q.pop_front()), lanes);
         check({14'h0000, seen_rd, seen_wr}, {14'h0000, ~w, w}, 16'h0003);
      end
   endtask
   // ==========================================
   // Main sequence
   // ==========================================
   initial
   begin
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      rstn_i = 1'b1;
      repeat (10) @(negedge clk_i);
      for (int i = 0; i < 32; i++)
      begin
         latch_sel_i = i[3];
         block_selected_i = (i < 16) ? 1'b1 : 1'($random(seed));
         // Second half uses the level write input; reads stay low-active
         wr_mode_i = i[4] ? WR_MODE_RNW : WR_MODE_STROBE;
         rd_mode_i = i[0] ? RD_MODE_FETCH : (i[4] ? RD_MODE_DSTROBE : RD_MODE_STROBE);
         xfer(i[2], st[i % 4]);
      end
      // Unselected so that a high-active read mode cannot make the device drive
      block_selected_i = 1'b0;
      for (int m = 0; m < 4; m++)
      begin
         rd_mode_i = 2'(m);
         wr_mode_i = m[0];
         fetch_present_i = m[1];
         repeat (8) @(negedge clk_i);
         // Idle E clock is high with the level input reading, so only mode 1 reads
         check({10'h000, read_active_o, write_active_o,
            wr_term_o, rd_term_o, fetch_term_o, general_in_o},
            {10'h000, (m == 1), 1'b0, bus_front_if_inst.write_control_input,
            bus_front_if_inst.read_control_input,
            fetch_present_i ? bus_front_if_inst.program_fetch_input : 1'b1,
            fetch_present_i ? 1'b1 : bus_front_if_inst.program_fetch_input},
            16'h003f);
      end
      rd_mode_i = RD_MODE_STROBE;
      wr_mode_i = WR_MODE_STROBE;
      block_selected_i = 1'b1;
      rstn_i = 1'b0;
      repeat (4) @(negedge clk_i);
      check(addr_o, 16'h0000, 16'hffff);
      check({15'h0000, port_reset_o}, 16'h0001, 16'h0001);
      rstn_i = 1'b1;
      repeat (10) @(negedge clk_i);
      check({15'h0000, port_reset_o}, 16'h0000, 16'h0001);
      xfer(1'b0, STYLE_BURST);
      print_verdict();
   end
endmodule
